// file: hw/eeprom_host_pkg.sv
// constants for the parallel eeprom host controller
// assumes a 20 MHz system clock driving every timing count
package eeprom_host_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ADDR_W        = 13;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PAGE_BYTES    = 32;
  localparam int unsigned PAGE_OFS_W    = 5;
  localparam int unsigned POLL_BIT      = 7;
  // times as printed
  localparam int unsigned WRITE_CYCLE_TIME_MS = 10;
  localparam int unsigned WRITE_START_TIME_NS = 150;
  localparam int unsigned BYTE_LOAD_GAP_US    = 30;
  localparam int unsigned STROBE_WIDTH_NS     = 200;
  localparam int unsigned DATA_SETUP_NS       = 100;
  localparam int unsigned DATA_HOLD_NS        = 20;
  localparam int unsigned READ_ACCESS_NS      = 250;
  localparam int unsigned RESET_HIGH_US       = 1;
  // cycle counts: least times round up, longest round down
  localparam int unsigned WR_CYCLE_CYC =
    (WRITE_CYCLE_TIME_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_START_CYC =
    (WRITE_START_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_MAX_CYC  =
    (BYTE_LOAD_GAP_US * 1000) / CLK_NS;
  // edges from a take to its strobe fall plus the strobe, hold and gap states' own lag
  localparam int unsigned SEQ_LAG_CYC  = 4;
  localparam int unsigned STROBE_CYC   =
    (STROBE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_CYC    =
    (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC     =
    (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_CYC     =
    (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned RST_HIGH_CYC =
    (RESET_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [5:0] COUNT_ZERO = 6'h00;
  localparam logic [5:0] COUNT_ONE  = 6'h01;
  localparam logic [4:0] IDX_ZERO   = 5'h00;
  localparam logic [4:0] IDX_ONE    = 5'h01;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
endpackage

// file: hw/eeprom_host.sv
// host controller that loads pages into a parallel eeprom and waits
// for the internal write, by polling bit 7, the ready/busy pin or a timer
// assumes one 20 MHz clock; device pins are sampled as synchronous inputs
`timescale 1ns/1ns
module eeprom_host
  import eeprom_host_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_protect,     // hold device in protect
  input  wire logic [1:0]        i_wait_mode,   // 0 timer, 1 poll, 2 rdy
  input  wire logic              i_load_valid,  // byte offered for page
  input  wire logic [ADDR_W-1:0] i_load_addr,
  input  wire logic [DATA_W-1:0] i_load_data,
  input  wire logic              i_load_last,   // closes the page
  input  wire logic              i_rd_req,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  input  wire logic [DATA_W-1:0] i_dq_in,
  input  wire logic              i_ready_busy,  // pulled-up pin level
  output logic                   o_load_ready,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_busy,
  output logic                   o_page_err,    // address left the page
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_dq_out,
  output logic                   o_dq_oe,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n,
  output logic                   o_protect_reset_n
);

  typedef enum logic [8:0] {
    ST_PROT   = 9'h001,
    ST_IDLE   = 9'h002,
    ST_SETUP  = 9'h004,
    ST_STROBE = 9'h008,
    ST_HOLD   = 9'h010,
    ST_GAP    = 9'h020,
    ST_WAIT   = 9'h040,
    ST_POLL   = 9'h080,
    ST_READ   = 9'h100
  } state_e;

  state_e               state_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [ADDR_W-1:0]    page_q;
  logic [DATA_W-1:0]    last_q;
  logic [1:0]           mode_q;
  logic                 wr_req;
  logic                 in_page;
  logic                 cnt_done;

  assign cnt_done = (cnt_q == CNT_ZERO);
  assign wr_req   = i_load_valid && o_load_ready;
  // upper bits must match the page latched by the first byte
  assign in_page  = (i_load_addr[ADDR_W-1:PAGE_OFS_W] ==
                     page_q[ADDR_W-1:PAGE_OFS_W]);

  // main sequencer; strobe timing drives the device latches
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_PROT;
      // reset pin needs its high time before the first access
      cnt_q   <= CNT_W'(RST_HIGH_CYC);
    end else begin
      if (!cnt_done) begin
        cnt_q <= cnt_q - CNT_ONE;
      end
      unique case (state_q)
        ST_PROT: begin
          // device stays unprogrammable until released and settled
          if (i_protect) begin
            cnt_q <= CNT_W'(RST_HIGH_CYC);
          end else if (cnt_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wr_req) begin
            state_q <= ST_SETUP;
            cnt_q   <= CNT_W'(SETUP_CYC);
          end else if (i_rd_req) begin
            state_q <= ST_READ;
            cnt_q   <= CNT_W'(READ_CYC);
          end
        end
        ST_SETUP: begin
          // we falls here: device latches address on this edge
          state_q <= ST_STROBE;
          cnt_q   <= CNT_W'(STROBE_CYC);
        end
        ST_STROBE: begin
          // strobe far wider than 20 ns so it is never filtered
          if (cnt_done) begin
            state_q <= ST_HOLD;
            cnt_q   <= CNT_W'(HOLD_CYC);
          end
        end
        ST_HOLD: begin
          if (cnt_done) begin
            state_q <= ST_GAP;
            // lag edges counted too, so a late take still keeps the
            // next falling strobe inside 30 us of the last one
            cnt_q   <= CNT_W'(GAP_MAX_CYC - STROBE_CYC - HOLD_CYC -
                              SEQ_LAG_CYC);
          end
        end
        ST_GAP: begin
          // next byte must follow in time or the page closes
          if (wr_req) begin
            state_q <= ST_SETUP;
            cnt_q   <= CNT_W'(SETUP_CYC);
          end else if (cnt_done) begin
            state_q <= ST_WAIT;
            cnt_q   <= (mode_q == 2'h0) ? CNT_W'(WR_CYCLE_CYC)
                                        : CNT_W'(WR_START_CYC);
          end
        end
        ST_WAIT: begin
          if (cnt_done) begin
            if (mode_q == 2'h0) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_POLL;
              cnt_q   <= CNT_W'(READ_CYC);
            end
          end
        end
        ST_POLL: begin
          if (mode_q == 2'h2) begin
            if (i_ready_busy) begin
              state_q <= ST_IDLE;
            end
          end else if (cnt_done) begin
            if (i_dq_in[POLL_BIT] == last_q[POLL_BIT]) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_WAIT;
              cnt_q   <= CNT_W'(WR_START_CYC);
            end
          end
        end
        ST_READ: begin
          if (cnt_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_PROT;
        end
      endcase
      // protect request wins, but never mid-write (it would abort it)
      if (i_protect && (state_q == ST_IDLE || state_q == ST_READ)) begin
        state_q <= ST_PROT;
        cnt_q   <= CNT_W'(RST_HIGH_CYC);
      end
    end
  end

  // page bookkeeping: base address, byte count, last data
  logic [5:0] count_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      page_q     <= '0;
      last_q     <= BYTE_ZERO;
      count_q    <= COUNT_ZERO;
      mode_q     <= 2'h0;
      o_page_err <= 1'b0;
    end else begin
      if (wr_req) begin
        last_q <= i_load_data;
        if (state_q == ST_IDLE) begin
          page_q     <= i_load_addr;
          count_q    <= COUNT_ONE;
          mode_q     <= (i_wait_mode == 2'h3) ? 2'h0 : i_wait_mode;
          o_page_err <= 1'b0;
        end else begin
          count_q    <= count_q + COUNT_ONE;
          o_page_err <= o_page_err | ~in_page;
        end
      end
    end
  end

  // load ready: idle, or inside the gap with room left in the page
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_load_ready <= 1'b0;
    end else begin
      o_load_ready <= 1'b0;
      if (!wr_req && !i_protect) begin
        if (state_q == ST_IDLE && !i_rd_req) begin
          o_load_ready <= 1'b1;
        end else if (state_q == ST_GAP && count_q < 6'(PAGE_BYTES)
                     && !cnt_done && !i_load_last) begin
          o_load_ready <= 1'b1;
        end
      end
    end
  end

  // device pins; reset pin high for every access
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_protect_reset_n <= 1'b0;
      o_ce_n   <= 1'b1;
      o_oe_n   <= 1'b1;
      o_we_n   <= 1'b1;
      o_dq_oe  <= 1'b0;
      o_dq_out <= BYTE_ZERO;
      o_addr   <= '0;
    end else begin
      o_protect_reset_n <= (state_q != ST_PROT) || !i_protect;
      if (wr_req) begin
        o_addr   <= i_load_addr;
        o_dq_out <= i_load_data;
      end else if (state_q == ST_IDLE && i_rd_req) begin
        o_addr   <= i_rd_addr;
      end
      o_ce_n  <= !(state_q == ST_SETUP || state_q == ST_STROBE ||
                   state_q == ST_POLL  || state_q == ST_READ);
      o_we_n  <= !(state_q == ST_SETUP || state_q == ST_STROBE);
      o_oe_n  <= !((state_q == ST_POLL && mode_q != 2'h2) ||
                   state_q == ST_READ);
      // drive data through the hold time after the rising strobe
      o_dq_oe <= (state_q == ST_SETUP || state_q == ST_STROBE ||
                  state_q == ST_HOLD) && !(state_q == ST_HOLD
                  && cnt_done);
    end
  end

  // read return and busy status
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= BYTE_ZERO;
      o_busy     <= 1'b1;
    end else begin
      o_rd_valid <= (state_q == ST_READ) && cnt_done;
      if (state_q == ST_READ && cnt_done) begin
        o_rd_data <= i_dq_in;
      end
      // busy covers the 1 us the reset pin must stay high
      o_busy <= (state_q != ST_IDLE);
    end
  end

endmodule // eeprom_host

// file: test/eeprom_host_props.sv
// pin assertions for the eeprom host controller
// assumes the package constants and one 20 MHz clock
`timescale 1ns/1ns
module eeprom_host_props
  import eeprom_host_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rstn,
  input wire logic              o_rd_valid,
  input wire logic              o_busy,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_dq_out,
  input wire logic              o_dq_oe,
  input wire logic              o_ce_n,
  input wire logic              o_oe_n,
  input wire logic              o_we_n,
  input wire logic              o_protect_reset_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [9:0] gap_q;
  // cycles since the strobe fell; saturates so page breaks never count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      gap_q <= 10'h3ff;
    else if (!o_we_n && $past(o_we_n))
      gap_q <= 10'h000;
    else if (gap_q != 10'h3ff)
      gap_q <= gap_q + 10'h001;
  end
  // falls are seen one edge late, so 600 cycles between falls reads as
  // 599; the first byte of a page (host was idle) has no gap to keep
  gap_limit_a: assert property ($fell(o_we_n) && $past(o_busy)
    |-> gap_q <= 10'h256) else $error("byte gap too long");
  reset_high_a: assert property (!o_ce_n |-> o_protect_reset_n)
    else $error("select with reset low");
  protect_idle_a: assert property ($fell(o_protect_reset_n)
    |-> !$past(o_busy)) else $error("protect while busy");
  power_hold_a: assert property ($rose(i_rstn) |-> !o_protect_reset_n)
    else $error("reset pin high at release");
  strobe_width_a: assert property ($fell(o_we_n)
    |-> (!o_we_n && !o_ce_n) [*4]) else $error("strobe too short");
  data_held_a: assert property (!o_we_n |=> $stable(o_addr)
    && $stable(o_dq_out) && o_dq_oe) else $error("data moved");
  poll_read_a: assert property ($fell(o_oe_n) |-> !o_ce_n
    && o_we_n && !o_dq_oe) else $error("bad poll read");
  rd_pulse_a: assert property (o_rd_valid |=> !o_rd_valid)
    else $error("read valid too long");
  cover property ($fell(o_we_n) && gap_q <= 10'h258);
  cover property ($fell(o_oe_n));
  cover property ($fell(o_protect_reset_n));
endmodule // eeprom_host_props

bind eeprom_host eeprom_host_props eeprom_host_props_i (.i_clk, .i_rstn,
  .o_rd_valid, .o_busy, .o_addr, .o_dq_out, .o_dq_oe, .o_ce_n, .o_oe_n,
  .o_we_n, .o_protect_reset_n);

// file: test/eeprom_dev_model.sv
// behavioural paged eeprom facing the host controller
// assumes ready/busy is seen with its pull-up already applied
`timescale 1ns/1ns
module eeprom_dev_model (
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_res_n,
  output logic      [7:0]  o_dq,
  output logic             o_rb
);
  logic [7:0]  mem [8192];
  logic [12:0] pg_a [$];
  logic [7:0]  pg_d [$];
  logic [12:0] a_q;
  logic [7:0]  last_q;
  logic [7:0]  junk_q = 8'h5a;
  logic        busy_q = 1'b0;
  logic        rb_q   = 1'b1;
  time         t_fall = 0;
  time         t_load = 0;
  int          wr_ns  = 20_000; // write time, raised by the bench
  wire strobe = i_ce_n | i_we_n;
  wire rd_now = !i_ce_n && !i_oe_n && i_we_n;
  // released bus toggles so a stale value is never mistaken for data
  always #50 junk_q = ~junk_q;
  always @(negedge strobe) begin
    t_fall = $time;
    a_q = i_addr;
  end
  // pulses of 20 ns or less never load a byte
  always @(posedge strobe) begin
    if (i_res_n && !busy_q && $time - t_fall > 20 &&
        pg_a.size() < 32) begin
      pg_a.push_back(a_q);
      pg_d.push_back(i_dq);
      last_q = i_dq;
      rb_q = 1'b0;
      t_load = $time;
    end
  end
  // page closes after 100 us quiet or when a read arrives
  always begin
    #100;
    if (pg_a.size() > 0 && ($time - t_load >= 100_000 || rd_now)) begin
      busy_q = 1'b1;
      for (int n = 0; n < wr_ns && i_res_n; n += 100) #100;
      foreach (pg_a[k])
        mem[pg_a[k]] = i_res_n ? pg_d[k] : junk_q;
      pg_a.delete();
      pg_d.delete();
      busy_q = 1'b0;
      rb_q = 1'b1;
    end
  end
  assign o_dq = !(i_res_n && rd_now) ? junk_q :
    (busy_q || rb_q == 1'b0) ? {~last_q[7], last_q[6:0]} :
    mem[i_addr];
  assign o_rb = rb_q;
endmodule // eeprom_dev_model

// file: test/tb.sv
// self-checking bench for the eeprom host controller
// assumes the device model and a 20 MHz clock
`timescale 1ns/1ns
module tb;
  import eeprom_host_pkg::*;
  logic              i_clk, i_rstn, i_protect, i_load_valid, i_load_last;
  logic              i_rd_req, o_load_ready, o_rd_valid, o_busy, o_page_err;
  logic              o_dq_oe, o_ce_n, o_oe_n, o_we_n, o_protect_reset_n;
  logic              rb_pin;
  logic [1:0]        i_wait_mode;
  logic [ADDR_W-1:0] i_load_addr, i_rd_addr, o_addr;
  logic [DATA_W-1:0] i_load_data, o_rd_data, o_dq_out, dev_dq, dq_bus;
  int                miscompares, total_checks;
  assign dq_bus = o_dq_oe ? o_dq_out : dev_dq; // host wins only when driving
  eeprom_host eeprom_host_i (.i_clk, .i_rstn, .i_protect, .i_wait_mode,
    .i_load_valid, .i_load_addr, .i_load_data, .i_load_last, .i_rd_req,
    .i_rd_addr, .i_dq_in(dq_bus), .i_ready_busy(rb_pin), .o_load_ready,
    .o_rd_valid, .o_rd_data, .o_busy, .o_page_err, .o_addr, .o_dq_out,
    .o_dq_oe, .o_ce_n, .o_oe_n, .o_we_n, .o_protect_reset_n);
  eeprom_dev_model eeprom_dev_model_i (.i_addr(o_addr), .i_dq(dq_bus),
    .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_res_n(o_protect_reset_n), .o_dq(dev_dq), .o_rb(rb_pin));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e,
                     input logic [12:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // waits on falling edges: 0 load ready, 1 idle, 2 read valid
  task automatic wait_for(input int k, input int lim);
    logic s;
    int n = 0;
    do begin
      @(negedge i_clk);
      n++;
      s = (k == 0) ? o_load_ready :
          (k == 1) ? (!o_busy && o_load_ready) : o_rd_valid;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      chk("wait", 13'h0001, 13'h0000);
      finish_test();
    end
    @(posedge i_clk);
  endtask
  task automatic load(input logic [12:0] a, input logic [7:0] d, input logic l);
    i_load_valid <= 1'b1;
    i_load_addr <= a;
    i_load_data <= d;
    wait_for(0, 2000);
    // last goes up only once the final byte is taken: the host takes
    // no further byte of the page while it stands
    if (l)
      i_load_last <= 1'b1;
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    i_rd_req <= 1'b1;
    i_rd_addr <= a;
    @(posedge i_clk);
    i_rd_req <= 1'b0;
    wait_for(2, 50);
    chk("read", {5'h00, e}, {5'h00, o_rd_data});
  endtask
  task automatic end_page(input int lim);
    i_load_valid <= 1'b0;
    wait_for(1, lim);
    i_load_last <= 1'b0;
    chk("dev busy", 13'h0000,
        {12'h000, eeprom_dev_model_i.busy_q});
  endtask
  task automatic t_page();
    i_wait_mode <= 2'h1;
    for (int k = 0; k < 32; k++)
      load(13'h0040 + 13'(k), 8'ha0 + 8'(k), k == 31);
    end_page(5000);
    for (int k = 0; k < 32; k++)
      chk("mem", {5'h00, 8'ha0 + 8'(k)},
          {5'h00, eeprom_dev_model_i.mem[13'h0040 + 13'(k)]});
    chk("page err", 13'h0000, {12'h000, o_page_err});
    rd(13'h005f, 8'hbf);
    $display("t_page done");
  endtask
  task automatic t_err();
    load(13'h0100, 8'h11, 1'b0);
    load(13'h0200, 8'h22, 1'b1);
    end_page(5000);
    chk("page err", 13'h0001, {12'h000, o_page_err});
    $display("t_err done");
  endtask
  task automatic t_rdy();
    eeprom_dev_model_i.wr_ns = 1_000_000;
    i_wait_mode <= 2'h2;
    load(13'h1fff, 8'h3c, 1'b1);
    end_page(40000);
    chk("mem", 13'h003c, {5'h00, eeprom_dev_model_i.mem[13'h1fff]});
    $display("t_rdy done");
  endtask
  // timer mode (code 3 runs as timer): host stays busy and never reads
  // long after the device is done; a mid-run reset then cuts it short
  task automatic t_timer();
    int held = 0;
    eeprom_dev_model_i.wr_ns = 20_000;
    i_wait_mode <= 2'h3;
    load(13'h0400, 8'h5a, 1'b0);
    i_load_valid <= 1'b0;
    @(posedge i_clk);
    repeat (3000) begin
      @(negedge i_clk);
      held += (o_busy === 1'b1 && o_oe_n === 1'b1);
    end
    chk("timer busy", 13'h0bb8, 13'(held));
    chk("dev busy", 13'h0000, {12'h000, eeprom_dev_model_i.busy_q});
    chk("mem", 13'h005a, {5'h00, eeprom_dev_model_i.mem[13'h0400]});
    // device already finished, so the early reset costs no data
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_for(1, 200);
    chk("reset pin", 13'h0001, {12'h000, o_protect_reset_n});
    $display("t_timer done");
  endtask
  task automatic t_prot();
    int seen = 0;
    i_protect <= 1'b1;
    i_rd_req <= 1'b1;
    repeat (30) begin
      @(negedge i_clk);
      seen += (o_rd_valid !== 1'b0);
    end
    chk("reset pin", 13'h0000, {12'h000, o_protect_reset_n});
    chk("refused reads", 13'h0000, 13'(seen));
    @(posedge i_clk);
    i_protect <= 1'b0;
    i_rd_req <= 1'b0;
    wait_for(1, 200);
    $display("t_prot done");
  endtask
  initial begin
    {i_rstn, i_protect, i_load_valid, i_load_last, i_rd_req} = 5'h00;
    {i_wait_mode, i_load_addr, i_rd_addr, i_load_data} = 36'h0;
    repeat (10) @(posedge i_clk);
    chk("reset pin", 13'h0000, {12'h000, o_protect_reset_n});
    i_rstn <= 1'b1;
    wait_for(1, 200);
    t_page();
    t_err();
    t_rdy();
    t_timer();
    t_prot();
    finish_test();
  end
endmodule // tb
